// File: verilog/dcr_pkg.sv
/*
 * shared constants and types for the dynamic core ratio divider.
 * assumes a single core clock domain; strap codes are 6-bit pll configuration codes.
 */
package dcr_pkg;

    // ------------------------------------------------------------
    // divide modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DCR_FULL    = 3'b001,
        DCR_HALF    = 3'b010,
        DCR_QUARTER = 3'b100
    } dcr_mode_e;

    // ------------------------------------------------------------
    // strap and ratio codes (code bit 5 is the first code position)
    // ------------------------------------------------------------
    localparam logic [5:0] DCR_STRAP_24X     = 6'h1a;
    localparam logic [5:0] DCR_STRAP_28X     = 6'h3a;
    localparam logic [5:0] DCR_CODE_24_FULL  = 6'h1a;
    localparam logic [5:0] DCR_CODE_24_HALF  = 6'h2e;
    localparam logic [5:0] DCR_CODE_24_QUART = 6'h34;
    localparam logic [5:0] DCR_CODE_28_FULL  = 6'h3a;
    localparam logic [5:0] DCR_CODE_28_HALF  = 6'h32;
    localparam logic [5:0] DCR_CODE_28_QUART = 6'h08;

    // multipliers in quarter steps so n.25x and n.75x stay exact
    localparam logic [7:0] DCR_MULT_24_FULL  = 8'h60;
    localparam logic [7:0] DCR_MULT_24_HALF  = 8'h30;
    localparam logic [7:0] DCR_MULT_24_QUART = 8'h18;
    localparam logic [7:0] DCR_MULT_28_FULL  = 8'h70;
    localparam logic [7:0] DCR_MULT_28_HALF  = 8'h38;
    localparam logic [7:0] DCR_MULT_28_QUART = 8'h1c;
    localparam logic [7:0] DCR_MULT_UNKNOWN  = 8'h00;

    // ------------------------------------------------------------
    // control register field positions of the ratio code
    // ------------------------------------------------------------
    localparam int DCR_POS_C5 = 15;
    localparam int DCR_POS_C4 = 16;
    localparam int DCR_POS_C3 = 17;
    localparam int DCR_POS_C2 = 18;
    localparam int DCR_POS_C1 = 19;
    localparam int DCR_POS_C0 = 14;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0]  DCR_RST_STRAP = 6'h00;
    localparam logic [5:0]  DCR_RST_CODE  = 6'h00;
    localparam logic [31:0] DCR_RST_CTRL  = 32'h0000_0000;
    localparam logic [1:0]  DCR_RST_PINS  = 2'h3;

    typedef struct packed {
        logic       ok;
        logic [5:0] code;
        logic [7:0] mult_q;
    } dcr_ratio_s;

endpackage : dcr_pkg

// File: verilog/dcr_divider.sv
/*
 * dynamic core ratio divider: picks full, halved or quartered core-to-bus
 * multiplier from software select bits and two active-low board pins.
 * assumes straps are stable around reset release and the pins are
 * asynchronous to core_clk.
 */
// How it works
// - divide multiplier by two or four, no reset
// - half bit set with quarter bit clear, or half pin low, halves
// - clearing bit or releasing pin restores full
// - quarter bit set or quarter pin low quarters
// - software mode change lands on next clock edge, pin change on the third
// - one pin low overrides software bits
// - both pins low forces full, ignores software
// - allowed modes depend on captured strap ratio
// - unsupported request keeps present multiplier
// - unsupported from full stays at strap multiplier
// - unsupported quarter from half stays halved
// - ratio code always shows effective multiplier
// - 24x codes 011010, 101110, 110100
// - 28x codes 111010, 110010, 001000
// - code bits at 15,16,17,18,19,14
// - fractional ratios report nearest lower code
`timescale 1ns/10ps
module dcr_divider (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic [5:0]          strap_cfg,
    input  wire logic                half_speed_select_bit,
    input  wire logic                quarter_speed_select_bit,
    input  wire logic                half_speed_request_pin_n,
    input  wire logic                quarter_speed_request_pin_n,
    output logic [5:0]               effective_ratio_code_ff,
    output logic [31:0]              impl_control_reg_one_ff,
    output dcr_pkg::dcr_mode_e       mode_ff,
    output logic [7:0]               mult_q_ff,
    output logic                     scaling_disabled_ff
);
    import dcr_pkg::*;

    // ------------------------------------------------------------
    // ratio table
    // ------------------------------------------------------------
    // unknown straps allow only full speed; code mirrors the strap
    function automatic dcr_ratio_s dcr_lookup(input logic [5:0] strap, input dcr_mode_e mode);
        dcr_ratio_s r;
        r = '{ok: 1'b0, code: strap, mult_q: DCR_MULT_UNKNOWN};
        if (strap == DCR_STRAP_24X) begin
            case (mode)
                DCR_HALF:    r = '{ok: 1'b1, code: DCR_CODE_24_HALF, mult_q: DCR_MULT_24_HALF};
                DCR_QUARTER: r = '{ok: 1'b1, code: DCR_CODE_24_QUART, mult_q: DCR_MULT_24_QUART};
                default:     r = '{ok: 1'b1, code: DCR_CODE_24_FULL, mult_q: DCR_MULT_24_FULL};
            endcase
        end else if (strap == DCR_STRAP_28X) begin
            case (mode)
                DCR_HALF:    r = '{ok: 1'b1, code: DCR_CODE_28_HALF, mult_q: DCR_MULT_28_HALF};
                DCR_QUARTER: r = '{ok: 1'b1, code: DCR_CODE_28_QUART, mult_q: DCR_MULT_28_QUART};
                default:     r = '{ok: 1'b1, code: DCR_CODE_28_FULL, mult_q: DCR_MULT_28_FULL};
            endcase
        end else if (mode == DCR_FULL) begin
            r.ok = 1'b1;
        end
        // code is a table entry, so fractional ratios keep exact mult_q
        // while the code is the lower valid one
        return r;
    endfunction : dcr_lookup

    // ------------------------------------------------------------
    // pin synchroniser and strap capture
    // ------------------------------------------------------------
    logic [1:0] pin_meta_ff;
    logic [1:0] pin_sync_ff;
    logic [1:0] nxt_pin_meta;
    logic [1:0] nxt_pin_sync;
    logic [5:0] strap_ff;
    logic [5:0] nxt_strap;
    logic       captured_ff;
    logic       nxt_captured;

    always_comb begin
        nxt_pin_meta = {half_speed_request_pin_n, quarter_speed_request_pin_n};
        nxt_pin_sync = pin_meta_ff;
        nxt_strap    = captured_ff ? strap_ff : strap_cfg;
        nxt_captured = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_ff <= DCR_RST_PINS;
            pin_sync_ff <= DCR_RST_PINS;
            strap_ff    <= DCR_RST_STRAP;
            captured_ff <= 1'b0;
        end else begin
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
            strap_ff    <= nxt_strap;
            captured_ff <= nxt_captured;
        end
    end

    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    logic        half_pin_low;
    logic        quart_pin_low;
    logic [5:0]  cfg;
    dcr_mode_e   req_mode;
    logic        req_dis;
    dcr_ratio_s  req_ent;
    dcr_ratio_s  out_ent;
    dcr_mode_e   nxt_mode;
    logic        nxt_dis;
    logic [5:0]  nxt_code;
    logic [31:0] nxt_ctrl;
    logic [7:0]  nxt_mult;

    assign half_pin_low  = ~pin_sync_ff[1];
    assign quart_pin_low = ~pin_sync_ff[0];

    always_comb begin
        cfg      = captured_ff ? strap_ff : strap_cfg;
        req_dis  = 1'b0;
        req_mode = DCR_FULL;
        if (half_pin_low && quart_pin_low) begin
            req_dis  = 1'b1;
            req_mode = DCR_FULL;
        end else if (half_pin_low) begin
            req_mode = DCR_HALF;
        end else if (quart_pin_low) begin
            req_mode = DCR_QUARTER;
        end else if (quarter_speed_select_bit) begin
            req_mode = DCR_QUARTER;
        end else if (half_speed_select_bit) begin
            req_mode = DCR_HALF;
        end else begin
            req_mode = DCR_FULL;
        end
        req_ent = dcr_lookup(cfg, req_mode);
        // refused requests hold the present mode
        nxt_mode = req_ent.ok ? req_mode : mode_ff;
        nxt_dis  = req_dis;
        out_ent  = dcr_lookup(cfg, nxt_mode);
        nxt_code = out_ent.code;
        nxt_mult = out_ent.mult_q;
        nxt_ctrl = DCR_RST_CTRL;
        nxt_ctrl[DCR_POS_C5] = nxt_code[5];
        nxt_ctrl[DCR_POS_C4] = nxt_code[4];
        nxt_ctrl[DCR_POS_C3] = nxt_code[3];
        nxt_ctrl[DCR_POS_C2] = nxt_code[2];
        nxt_ctrl[DCR_POS_C1] = nxt_code[1];
        nxt_ctrl[DCR_POS_C0] = nxt_code[0];
    end

    // full speed from reset; strap is read directly on the first edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff                 <= DCR_FULL;
            scaling_disabled_ff     <= 1'b0;
            effective_ratio_code_ff <= DCR_RST_CODE;
            impl_control_reg_one_ff <= DCR_RST_CTRL;
            mult_q_ff               <= DCR_MULT_UNKNOWN;
        end else begin
            mode_ff                 <= nxt_mode;
            scaling_disabled_ff     <= nxt_dis;
            effective_ratio_code_ff <= nxt_code;
            impl_control_reg_one_ff <= nxt_ctrl;
            mult_q_ff               <= nxt_mult;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_both_pins_full;
        @(posedge core_clk) disable iff (!rst_b)
        (half_pin_low && quart_pin_low) |=> (mode_ff == DCR_FULL) && scaling_disabled_ff;
    endproperty
    a_both_pins_full: assert property (p_both_pins_full) else $error("both pins low did not force full");

    property p_half_pin;
        @(posedge core_clk) disable iff (!rst_b)
        (half_pin_low && !quart_pin_low && dcr_lookup(cfg, DCR_HALF).ok) |=> mode_ff == DCR_HALF;
    endproperty
    a_half_pin: assert property (p_half_pin) else $error("half pin not followed");

    property p_quart_pin;
        @(posedge core_clk) disable iff (!rst_b)
        (quart_pin_low && !half_pin_low && dcr_lookup(cfg, DCR_QUARTER).ok) |=> mode_ff == DCR_QUARTER;
    endproperty
    a_quart_pin: assert property (p_quart_pin) else $error("quarter pin not followed");

    property p_sw_half;
        @(posedge core_clk) disable iff (!rst_b)
        (!half_pin_low && !quart_pin_low && half_speed_select_bit && !quarter_speed_select_bit
         && dcr_lookup(cfg, DCR_HALF).ok) |=> mode_ff == DCR_HALF;
    endproperty
    a_sw_half: assert property (p_sw_half) else $error("half select bit not followed");

    property p_release_full;
        @(posedge core_clk) disable iff (!rst_b)
        (!half_pin_low && !quart_pin_low && !half_speed_select_bit && !quarter_speed_select_bit)
        |=> mode_ff == DCR_FULL;
    endproperty
    a_release_full: assert property (p_release_full) else $error("did not return to full");

    property p_refused_holds;
        @(posedge core_clk) disable iff (!rst_b)
        !req_ent.ok |=> mode_ff == $past(mode_ff);
    endproperty
    a_refused_holds: assert property (p_refused_holds) else $error("unsupported request changed mode");

    property p_pin_sync_delay;
        @(posedge core_clk) disable iff (!rst_b)
        (!half_speed_request_pin_n && !quarter_speed_request_pin_n) [*3] |=> scaling_disabled_ff;
    endproperty
    a_pin_sync_delay: assert property (p_pin_sync_delay) else $error("pins not seen after sync");

    property p_code_24_half;
        @(posedge core_clk) disable iff (!rst_b)
        (captured_ff && strap_ff == DCR_STRAP_24X && mode_ff == DCR_HALF)
        |-> effective_ratio_code_ff == DCR_CODE_24_HALF;
    endproperty
    a_code_24_half: assert property (p_code_24_half) else $error("wrong 24x halved code");

    property p_code_28_quart;
        @(posedge core_clk) disable iff (!rst_b)
        (captured_ff && strap_ff == DCR_STRAP_28X && mode_ff == DCR_QUARTER)
        |-> effective_ratio_code_ff == DCR_CODE_28_QUART;
    endproperty
    a_code_28_quart: assert property (p_code_28_quart) else $error("wrong 28x quartered code");

    property p_field_layout;
        @(posedge core_clk) disable iff (!rst_b)
        impl_control_reg_one_ff[19:14] == {effective_ratio_code_ff[1], effective_ratio_code_ff[2],
            effective_ratio_code_ff[3], effective_ratio_code_ff[4], effective_ratio_code_ff[5],
            effective_ratio_code_ff[0]};
    endproperty
    a_field_layout: assert property (p_field_layout) else $error("ratio code field misplaced");

    property p_code_tracks_mode;
        @(posedge core_clk) disable iff (!rst_b)
        captured_ff |=> effective_ratio_code_ff == dcr_lookup($past(cfg), mode_ff).code;
    endproperty
    a_code_tracks_mode: assert property (p_code_tracks_mode) else $error("code does not match mode");

    c_half_to_quart: cover property (@(posedge core_clk) disable iff (!rst_b)
        mode_ff == DCR_HALF ##1 mode_ff == DCR_QUARTER);
    c_refused: cover property (@(posedge core_clk) disable iff (!rst_b)
        !req_ent.ok && mode_ff == DCR_FULL);
    c_disabled: cover property (@(posedge core_clk) disable iff (!rst_b)
        scaling_disabled_ff && quarter_speed_select_bit);

endmodule : dcr_divider

// File: tb/dcr_board_model.sv
/*
 * board-side driver of the two active-low divide request pins.
 * assumes the bench changes the request levels just after a core_clk edge.
 */
`timescale 1ns/10ps
module dcr_board_model (
    input  wire logic req_half,
    input  wire logic req_quarter,
    output logic      half_speed_request_pin_n,
    output logic      quarter_speed_request_pin_n
);
    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // pins are pulled up when released, so no stale level is left behind
    // the 24x and 28x divides are requested, plus divides on an unknown strap that the divider refuses
    assign half_speed_request_pin_n    = ~req_half;
    assign quarter_speed_request_pin_n = ~req_quarter;
endmodule : dcr_board_model

// File: tb/testbench.sv
/*
 * self-checking bench for the dynamic core ratio divider.
 * assumes the design outputs settle one edge after a software change
 * and three edges after a pin change.
 */
`timescale 1ns/10ps
module testbench;
    import dcr_pkg::*;
    logic                core_clk, rst_b;
    logic [5:0]          strap_cfg;
    logic                half_speed_select_bit, quarter_speed_select_bit;
    logic                req_half, req_quarter;
    logic                half_speed_request_pin_n, quarter_speed_request_pin_n;
    logic [5:0]          effective_ratio_code_ff;
    logic [31:0]         impl_control_reg_one_ff;
    dcr_mode_e           mode_ff;
    logic [7:0]          mult_q_ff;
    logic                scaling_disabled_ff;
    int                  num_errors, total_checks, cycle_cnt;
    logic [5:0]          strap_tab [2]    = '{6'h1a, 6'h3a};
    logic [5:0]          code_tab  [2][3] = '{'{6'h1a, 6'h2e, 6'h34}, '{6'h3a, 6'h32, 6'h08}};
    logic [7:0]          mult_tab  [2][3] = '{'{8'h60, 8'h30, 8'h18}, '{8'h70, 8'h38, 8'h1c}};
    dcr_mode_e           mode_tab  [3]    = '{DCR_FULL, DCR_HALF, DCR_QUARTER};

    dcr_divider dut_u (
        .core_clk                    (core_clk),
        .rst_b                       (rst_b),
        .strap_cfg                   (strap_cfg),
        .half_speed_select_bit       (half_speed_select_bit),
        .quarter_speed_select_bit    (quarter_speed_select_bit),
        .half_speed_request_pin_n    (half_speed_request_pin_n),
        .quarter_speed_request_pin_n (quarter_speed_request_pin_n),
        .effective_ratio_code_ff     (effective_ratio_code_ff),
        .impl_control_reg_one_ff     (impl_control_reg_one_ff),
        .mode_ff                     (mode_ff),
        .mult_q_ff                   (mult_q_ff),
        .scaling_disabled_ff         (scaling_disabled_ff)
    );
    dcr_board_model board_u (
        .req_half                    (req_half),
        .req_quarter                 (req_quarter),
        .half_speed_request_pin_n    (half_speed_request_pin_n),
        .quarter_speed_request_pin_n (quarter_speed_request_pin_n)
    );

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 3000) begin
            num_errors++;
            $display("[FAIL] %0t: watchdog expired", $time);
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // sample at the falling edge so the launching edge has fully landed
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : step

    task automatic set_sw(logic h, logic q);
        @(posedge core_clk);
        half_speed_select_bit    <= h;
        quarter_speed_select_bit <= q;
    endtask : set_sw

    task automatic set_pin(logic h, logic q);
        @(posedge core_clk);
        req_half    <= h;
        req_quarter <= q;
    endtask : set_pin

    function automatic logic [31:0] ctrl_of(logic [5:0] c);
        logic [31:0] r;
        r     = 32'h0;
        r[15] = c[5];
        r[16] = c[4];
        r[17] = c[3];
        r[18] = c[2];
        r[19] = c[1];
        r[14] = c[0];
        return r;
    endfunction : ctrl_of

    task automatic check_state(dcr_mode_e m, logic [5:0] c, logic [7:0] q, logic d);
        total_checks++;
        if (mode_ff !== m || effective_ratio_code_ff !== c || impl_control_reg_one_ff !== ctrl_of(c)
            || mult_q_ff !== q || scaling_disabled_ff !== d) begin
            num_errors++;
            $display("[FAIL] %0t: mode %b code %h mult %h dis %b", $time, mode_ff,
                     effective_ratio_code_ff, mult_q_ff, scaling_disabled_ff);
        end
    endtask : check_state

    task automatic check_idx(int s, int i, logic d);
        check_state(mode_tab[i], code_tab[s][i], mult_tab[s][i], d);
    endtask : check_idx

    // a reset in mid-run also recaptures the strap
    task automatic do_reset(logic [5:0] s);
        @(posedge core_clk);
        rst_b     <= 1'b0;
        strap_cfg <= s;
        step(2);
        check_state(DCR_FULL, 6'h00, 8'h00, 1'b0);
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        step(3);
    endtask : do_reset

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_software(int s);
        do_reset(strap_tab[s]);
        check_idx(s, 0, 1'b0);
        set_sw(1'b1, 1'b0); step(1); check_idx(s, 1, 1'b0);
        set_sw(1'b1, 1'b1); step(1); check_idx(s, 2, 1'b0);
        set_sw(1'b0, 1'b0); step(1); check_idx(s, 0, 1'b0);
        set_sw(1'b0, 1'b1); step(1); check_idx(s, 2, 1'b0);
        set_sw(1'b1, 1'b0); step(1); check_idx(s, 1, 1'b0);
    endtask : t_software

    task automatic t_pins(int s);
        set_sw(1'b0, 1'b1); set_pin(1'b1, 1'b0); step(3); check_idx(s, 1, 1'b0);
        set_sw(1'b1, 1'b0); set_pin(1'b0, 1'b1); step(3); check_idx(s, 2, 1'b0);
        set_pin(1'b1, 1'b1); step(2); check_idx(s, 2, 1'b0);
        step(1); check_idx(s, 0, 1'b1);
        set_sw(1'b0, 1'b1); step(1); check_idx(s, 0, 1'b1);
        set_pin(1'b0, 1'b0); step(3); check_idx(s, 2, 1'b0);
        set_sw(1'b0, 1'b0); step(1); check_idx(s, 0, 1'b0);
    endtask : t_pins

    // strap outside the divide table: every divide request is refused
    task automatic t_unknown();
        do_reset(6'h10);
        check_state(DCR_FULL, 6'h10, 8'h00, 1'b0);
        set_sw(1'b1, 1'b0); step(1); check_state(DCR_FULL, 6'h10, 8'h00, 1'b0);
        set_sw(1'b0, 1'b1); step(1); check_state(DCR_FULL, 6'h10, 8'h00, 1'b0);
        set_sw(1'b0, 1'b0); set_pin(1'b0, 1'b1); step(3); check_state(DCR_FULL, 6'h10, 8'h00, 1'b0);
        set_pin(1'b1, 1'b1); step(3); check_state(DCR_FULL, 6'h10, 8'h00, 1'b1);
        set_pin(1'b0, 1'b0); step(3); check_state(DCR_FULL, 6'h10, 8'h00, 1'b0);
    endtask : t_unknown

    initial begin
        core_clk                 = 1'b0;
        rst_b                    = 1'b0;
        strap_cfg                = 6'h1a;
        half_speed_select_bit    = 1'b0;
        quarter_speed_select_bit = 1'b0;
        req_half                 = 1'b0;
        req_quarter              = 1'b0;
        num_errors               = 0;
        total_checks             = 0;
        cycle_cnt                = 0;
        for (int s = 0; s < 2; s++) begin
            t_software(s);
            set_sw(1'b0, 1'b0);
            t_pins(s);
        end
        t_unknown();
        stop_test();
    end
endmodule : testbench
